// >>> hdl/sac_pkg.sv
/*
 * Shared constants, types and decode functions of the converter control.
 * Assumes one clock domain; used through explicit package scope only.
 */
package sac_pkg;

  // ----------------------------------------------------------------
  // Widths and reset values
  // ----------------------------------------------------------------
  localparam int RES_W = 12;
  localparam int PA_N = 5;
  localparam int PB_N = 7;
  localparam int REF_N = 5;
  localparam logic [11:0] SAR_INIT = 12'h800;
  localparam logic [11:0] RESULT_RST = 12'h000;
  localparam logic [3:0] PTR_MSB = 4'hB;
  localparam logic DONE_RST = 1'b0;

  // ----------------------------------------------------------------
  // Channel codes and reference one-hot positions
  // ----------------------------------------------------------------
  localparam logic [3:0] CH_PA_LAST = 4'h4;
  localparam logic [3:0] CH_PB_FIRST = 4'h5;
  localparam logic [3:0] CH_PB_LAST = 4'hB;
  localparam logic [3:0] CH_QUARTER = 4'hC;
  localparam logic [3:0] CH_GROUND = 4'hD;
  localparam int REF_EXT = 0;
  localparam int REF_VDD = 1;
  localparam int REF_4V = 2;
  localparam int REF_3V = 3;
  localparam int REF_2V = 4;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE, ST_SAMPLE, ST_SETTLE, ST_CONVERT, ST_FINISH
  } sac_state_e;

  typedef struct packed {
    logic [1:0] div_sel;
    logic [1:0] samp_sel;
    logic [1:0] res_sel;
    logic ch_en;
    logic [3:0] ch_sel;
    logic ext_ref;
    logic [1:0] int_ref;
  } sac_cfg_s;

  typedef struct packed {
    logic [PA_N-1:0] pa_sel;
    logic [PB_N-1:0] pb_sel;
    logic quarter_sel;
    logic ground_sel;
    logic [REF_N-1:0] ref_sel;
  } sac_route_s;

  // ----------------------------------------------------------------
  // Decode functions
  // ----------------------------------------------------------------
  function automatic logic [4:0] sac_div_ratio(input logic [1:0] sel);
    case (sel)
      2'h0: sac_div_ratio = 5'h10;
      2'h1: sac_div_ratio = 5'h08;
      2'h2: sac_div_ratio = 5'h01;
      default: sac_div_ratio = 5'h02;
    endcase
  endfunction

  function automatic logic [3:0] sac_samp_ticks(input logic [1:0] sel);
    case (sel)
      2'h0: sac_samp_ticks = 4'h1;
      2'h1: sac_samp_ticks = 4'h2;
      2'h2: sac_samp_ticks = 4'h4;
      default: sac_samp_ticks = 4'h8;
    endcase
  endfunction

  function automatic logic [3:0] sac_res_bits(input logic [1:0] sel);
    case (sel)
      2'h0: sac_res_bits = 4'h8;
      2'h1: sac_res_bits = 4'hA;
      default: sac_res_bits = 4'hC;
    endcase
  endfunction

endpackage

// >>> hdl/sac_clkdiv.sv
/*
 * Converter clock enable divider.
 * Assumes MCLK is the instruction clock; clear restarts the phase.
 */
`timescale 1ns/1ps
module sac_clkdiv (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Control
  input wire logic clear,
  input wire logic [1:0] sel,
  // Enable pulse
  output logic tick
);

  logic [4:0] cnt_reg;
  logic [4:0] cnt_next;
  logic [4:0] ratio;

  always_comb begin
    ratio = sac_pkg::sac_div_ratio(sel);
    tick = (cnt_reg == ratio - 5'h01) && !clear;
    if (clear || tick) begin
      cnt_next = 5'h00;
    end else begin
      cnt_next = cnt_reg + 5'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_reg <= 5'h00;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

endmodule // sac_clkdiv

// >>> hdl/sac_sar.sv
/*
 * Successive-approximation trial register, MSB aligned.
 * Assumes comp is high when the input is at or above the trial code.
 */
`timescale 1ns/1ps
module sac_sar (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Control
  input wire logic init,
  input wire logic step,
  input wire logic comp,
  input wire logic [3:0] lsb_idx,
  // State
  output logic [11:0] code,
  output logic last
);

  logic [11:0] code_reg;
  logic [11:0] code_next;
  logic [3:0] ptr_reg;
  logic [3:0] ptr_next;

  always_comb begin
    code_next = code_reg;
    ptr_next = ptr_reg;
    if (init) begin
      code_next = sac_pkg::SAR_INIT;
      ptr_next = sac_pkg::PTR_MSB;
    end else if (step) begin
      code_next[ptr_reg] = comp;
      if (ptr_reg > lsb_idx) begin
        code_next[ptr_reg - 4'h1] = 1'b1;
        ptr_next = ptr_reg - 4'h1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      code_reg <= 12'h000;
      ptr_reg <= 4'h0;
    end else begin
      code_reg <= code_next;
      ptr_reg <= ptr_next;
    end
  end

  assign code = code_reg;
  assign last = (ptr_reg == lsb_idx);

endmodule // sac_sar

// >>> hdl/sac_ctrl.sv
/*
 * Conversion control of a successive-approximation converter: timing,
 * bit sequencing, done flag, interrupt pulse and analog routing selects.
 * Assumes all inputs are synchronous to MCLK and that the comparator
 * result is settled one MCLK after the trial code changes.
 */
// Overview of operation
// - Converter clock is instruction clock divided 16/8/1/2.
// - Sampling lasts 1, 2, 4 or 8 converter clocks.
// - Resolution 8, 10 or 12 bits by select.
// - Conversion takes sampling plus bits plus two clocks.
// - One result bit per converter clock.
// - Start request begins conversion when converter enabled.
// - Done flag low while busy, high when finished.
// - Interrupt on done rising with both enables set.
// - Channel codes select port A and B pins.
// - Codes for quarter supply, ground, or nothing.
// - External reference pin or internal level as reference.
// - Analog-only bit disconnects that pin's digital function.
`timescale 1ns/1ps
module sac_ctrl (
  // Clock and reset
  input wire logic MCLK,
  input wire logic RESETN,
  // Configuration
  input wire logic [1:0] CONVERTER_CLOCK_DIVIDER_SELECT,
  input wire logic [1:0] SAMPLE_WIDTH_SELECT,
  input wire logic [1:0] RESOLUTION_SELECT,
  input wire logic CHANNEL_MASTER_ENABLE,
  input wire logic [3:0] INPUT_CHANNEL_SELECT,
  input wire logic EXTERNAL_REF_ENABLE,
  input wire logic [1:0] INTERNAL_REF_LEVEL,
  input wire logic [sac_pkg::PA_N-1:0] PORTA_ANALOG_ONLY,
  input wire logic [sac_pkg::PB_N-1:0] PORTB_ANALOG_ONLY,
  // Control
  input wire logic CONVERTER_ENABLE,
  input wire logic CONVERSION_START,
  input wire logic CONVERSION_IRQ_ENABLE,
  input wire logic GLOBAL_IRQ_ENABLE,
  // Analog front end
  input wire logic COMPARATOR_OUT,
  output logic [sac_pkg::RES_W-1:0] TRIAL_CODE,
  output logic SAMPLE_PULSE,
  output logic CONVERTER_CLOCK,
  output sac_pkg::sac_route_s ANALOG_ROUTE,
  output logic [sac_pkg::PA_N-1:0] PORTA_DIGITAL_OFF,
  output logic [sac_pkg::PB_N-1:0] PORTB_DIGITAL_OFF,
  // Status
  output logic CONVERSION_DONE,
  output logic [sac_pkg::RES_W-1:0] CONVERSION_RESULT,
  output logic CONVERSION_IRQ
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  sac_pkg::sac_state_e state_reg;
  sac_pkg::sac_state_e state_next;
  sac_pkg::sac_cfg_s cfg_live;
  sac_pkg::sac_cfg_s cap_reg;
  sac_pkg::sac_cfg_s cap_next;
  sac_pkg::sac_cfg_s cfg_eff;
  sac_pkg::sac_route_s route_reg;
  sac_pkg::sac_route_s route_next;
  logic [3:0] samp_cnt_reg;
  logic [3:0] samp_cnt_next;
  logic done_reg;
  logic done_next;
  logic irq_reg;
  logic irq_next;
  logic [11:0] result_reg;
  logic [11:0] result_next;
  logic [sac_pkg::PA_N-1:0] pa_off_reg;
  logic [sac_pkg::PB_N-1:0] pb_off_reg;
  logic busy;
  logic start_ok;
  logic tick;
  logic sar_init;
  logic sar_step;
  logic sar_last;
  logic [11:0] sar_code;
  logic [3:0] lsb_idx;

  assign cfg_live = '{div_sel: CONVERTER_CLOCK_DIVIDER_SELECT,
                      samp_sel: SAMPLE_WIDTH_SELECT,
                      res_sel: RESOLUTION_SELECT,
                      ch_en: CHANNEL_MASTER_ENABLE,
                      ch_sel: INPUT_CHANNEL_SELECT,
                      ext_ref: EXTERNAL_REF_ENABLE,
                      int_ref: INTERNAL_REF_LEVEL};

  assign busy = (state_reg != sac_pkg::ST_IDLE);
  // Live settings only reach the datapath while idle
  assign cfg_eff = busy ? cap_reg : cfg_live;
  assign start_ok = CONVERSION_START && CONVERTER_ENABLE && !busy;
  assign lsb_idx = 4'(sac_pkg::RES_W) - sac_pkg::sac_res_bits(cap_reg.res_sel);

  // ----------------------------------------------------------------
  // Converter clock and trial register
  // ----------------------------------------------------------------
  // Divider restarts on start so conversion time does not depend on phase
  sac_clkdiv u_clkdiv (
    .clk(MCLK),
    .rst_n(RESETN),
    .clear(start_ok),
    .sel(cfg_eff.div_sel),
    .tick(tick)
  );

  sac_sar u_sar (
    .clk(MCLK),
    .rst_n(RESETN),
    .init(sar_init),
    .step(sar_step),
    .comp(COMPARATOR_OUT),
    .lsb_idx(lsb_idx),
    .code(sar_code),
    .last(sar_last)
  );

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    cap_next = cap_reg;
    samp_cnt_next = samp_cnt_reg;
    done_next = done_reg;
    result_next = result_reg;
    sar_init = 1'b0;
    sar_step = 1'b0;
    if (busy && !CONVERTER_ENABLE) begin
      // Disabling aborts; old result stays, done stays low
      state_next = sac_pkg::ST_IDLE;
    end else begin
      case (state_reg)
        sac_pkg::ST_IDLE: begin
          if (start_ok) begin
            cap_next = cfg_live;
            samp_cnt_next = 4'h0;
            done_next = 1'b0;
            sar_init = 1'b1;
            state_next = sac_pkg::ST_SAMPLE;
          end
        end
        sac_pkg::ST_SAMPLE: begin
          if (tick) begin
            if (samp_cnt_reg == sac_pkg::sac_samp_ticks(cap_reg.samp_sel) - 4'h1) begin
              state_next = sac_pkg::ST_SETTLE;
            end
            samp_cnt_next = samp_cnt_reg + 4'h1;
          end
        end
        sac_pkg::ST_SETTLE: begin
          if (tick) begin
            state_next = sac_pkg::ST_CONVERT;
          end
        end
        sac_pkg::ST_CONVERT: begin
          if (tick) begin
            sar_step = 1'b1;
            if (sar_last) begin
              state_next = sac_pkg::ST_FINISH;
            end
          end
        end
        sac_pkg::ST_FINISH: begin
          if (tick) begin
            result_next = sar_code;
            done_next = 1'b1;
            state_next = sac_pkg::ST_IDLE;
          end
        end
        default: begin
          state_next = sac_pkg::ST_IDLE;
        end
      endcase
    end
    irq_next = done_next && !done_reg && CONVERSION_IRQ_ENABLE && GLOBAL_IRQ_ENABLE;
  end

  // ----------------------------------------------------------------
  // Analog routing
  // ----------------------------------------------------------------
  always_comb begin
    route_next = '0;
    if (cfg_eff.ch_en) begin
      if (cfg_eff.ch_sel <= sac_pkg::CH_PA_LAST) begin
        route_next.pa_sel[cfg_eff.ch_sel[2:0]] = 1'b1;
      end else if (cfg_eff.ch_sel <= sac_pkg::CH_PB_LAST) begin
        route_next.pb_sel[3'(cfg_eff.ch_sel - sac_pkg::CH_PB_FIRST)] = 1'b1;
      end else if (cfg_eff.ch_sel == sac_pkg::CH_QUARTER) begin
        route_next.quarter_sel = 1'b1;
      end else if (cfg_eff.ch_sel == sac_pkg::CH_GROUND) begin
        route_next.ground_sel = 1'b1;
      end
    end
    if (cfg_eff.ext_ref) begin
      route_next.ref_sel[sac_pkg::REF_EXT] = 1'b1;
    end else begin
      case (cfg_eff.int_ref)
        2'h3: route_next.ref_sel[sac_pkg::REF_VDD] = 1'b1;
        2'h2: route_next.ref_sel[sac_pkg::REF_4V] = 1'b1;
        2'h1: route_next.ref_sel[sac_pkg::REF_3V] = 1'b1;
        default: route_next.ref_sel[sac_pkg::REF_2V] = 1'b1;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge MCLK) begin
    if (!RESETN) begin
      state_reg <= sac_pkg::ST_IDLE;
      cap_reg <= '0;
      samp_cnt_reg <= 4'h0;
      done_reg <= sac_pkg::DONE_RST;
      irq_reg <= 1'b0;
      result_reg <= sac_pkg::RESULT_RST;
      route_reg <= '0;
      pa_off_reg <= '0;
      pb_off_reg <= '0;
    end else begin
      state_reg <= state_next;
      cap_reg <= cap_next;
      samp_cnt_reg <= samp_cnt_next;
      done_reg <= done_next;
      irq_reg <= irq_next;
      result_reg <= result_next;
      route_reg <= route_next;
      pa_off_reg <= PORTA_ANALOG_ONLY;
      pb_off_reg <= PORTB_ANALOG_ONLY;
    end
  end

  assign TRIAL_CODE = sar_code;
  assign SAMPLE_PULSE = (state_reg == sac_pkg::ST_SAMPLE);
  assign CONVERTER_CLOCK = tick && busy;
  assign ANALOG_ROUTE = route_reg;
  assign PORTA_DIGITAL_OFF = pa_off_reg;
  assign PORTB_DIGITAL_OFF = pb_off_reg;
  assign CONVERSION_DONE = done_reg;
  assign CONVERSION_RESULT = result_reg;
  assign CONVERSION_IRQ = irq_reg;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  logic [4:0] gap_reg;
  logic [5:0] ticks_reg;

  // Cycles since last tick and ticks since start, for timing checks
  always_ff @(posedge MCLK) begin
    if (!RESETN) begin
      gap_reg <= 5'h00;
      ticks_reg <= 6'h00;
    end else begin
      gap_reg <= (start_ok || tick) ? 5'h01 : gap_reg + 5'h01;
      if (start_ok) begin
        ticks_reg <= 6'h00;
      end else if (busy && tick) begin
        ticks_reg <= ticks_reg + 6'h01;
      end
    end
  end

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RESETN);

  property p_div_gap;
    busy && tick && !start_ok |-> gap_reg == sac_pkg::sac_div_ratio(cap_reg.div_sel);
  endproperty
  a_div_gap: assert property (p_div_gap) else $error("converter clock spacing wrong");

  property p_sample_len;
    $fell(SAMPLE_PULSE) && state_reg == sac_pkg::ST_SETTLE
      |-> ticks_reg == 6'(sac_pkg::sac_samp_ticks(cap_reg.samp_sel));
  endproperty
  a_sample_len: assert property (p_sample_len) else $error("sampling length wrong");

  property p_conv_time;
    $rose(done_reg) |-> ticks_reg == 6'(sac_pkg::sac_samp_ticks(cap_reg.samp_sel))
      + 6'(sac_pkg::sac_res_bits(cap_reg.res_sel)) + 6'h02;
  endproperty
  a_conv_time: assert property (p_conv_time) else $error("conversion time wrong");

  property p_bit_per_tick;
    state_reg == sac_pkg::ST_CONVERT && !$past(tick) |-> $stable(sar_code);
  endproperty
  a_bit_per_tick: assert property (p_bit_per_tick) else $error("trial code moved off tick");

  property p_start;
    !busy && CONVERSION_START && CONVERTER_ENABLE |=> SAMPLE_PULSE && !done_reg;
  endproperty
  a_start: assert property (p_start) else $error("start not taken");

  property p_busy_done;
    busy |-> !done_reg;
  endproperty
  a_busy_done: assert property (p_busy_done) else $error("done high while busy");

  property p_irq;
    CONVERSION_IRQ |-> $rose(done_reg) && $past(CONVERSION_IRQ_ENABLE && GLOBAL_IRQ_ENABLE);
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt without cause");

  property p_no_route;
    !cfg_eff.ch_en |=> ANALOG_ROUTE.pa_sel == '0 && ANALOG_ROUTE.pb_sel == '0
      && !ANALOG_ROUTE.quarter_sel && !ANALOG_ROUTE.ground_sel;
  endproperty
  a_no_route: assert property (p_no_route) else $error("input routed while disabled");

  property p_ext_ref;
    cfg_eff.ext_ref |=> ANALOG_ROUTE.ref_sel == 5'h01;
  endproperty
  a_ext_ref: assert property (p_ext_ref) else $error("external reference not chosen");

  property p_analog_only;
    ##1 PORTA_DIGITAL_OFF == $past(PORTA_ANALOG_ONLY)
      && PORTB_DIGITAL_OFF == $past(PORTB_ANALOG_ONLY);
  endproperty
  a_analog_only: assert property (p_analog_only) else $error("digital disable wrong");

  property p_hold;
    busy && $past(busy) |-> $stable(cap_reg) && $stable(CONVERSION_RESULT);
  endproperty
  a_hold: assert property (p_hold) else $error("settings or result moved while busy");

  c_done_12: cover property ($rose(done_reg) && cap_reg.res_sel[1]);
  c_done_8: cover property ($rose(done_reg) && cap_reg.res_sel == 2'h0);
  c_irq: cover property (CONVERSION_IRQ);
  c_abort: cover property (busy && !CONVERTER_ENABLE);

endmodule // sac_ctrl

// >>> tb/tb_sac_ctrl.sv
/*
 * Self-checking bench for the converter control: routing decode, timing,
 * result, done flag, interrupt pulse, refused and aborted starts.
 * Assumes the design files under hdl/ are compiled first.
 */
`timescale 1ns/1ps
module tb_sac_ctrl;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic mclk, resetn;
  logic [1:0] div_sel, samp_sel, res_sel, int_ref;
  logic ch_en, ext_ref, conv_en, start, irq_en, gie, comp;
  logic [3:0] ch_sel;
  logic [4:0] pa_ao, pa_off;
  logic [6:0] pb_ao, pb_off;
  logic [11:0] trial, result, vin, prev;
  logic samp_pulse, conv_clk, done, irq, bad;
  sac_pkg::sac_route_s route;
  logic [11:0] vals [6] = '{12'h000, 12'hFFF, 12'h5A3, 12'hA5C, 12'h800, 12'h7FF};
  int fail_count, check_count, i, k;
  // Bias settling after enable: 256 us at the 4 ns clock
  localparam int BIAS_WAIT = 64000;

  sac_ctrl uut (
    .MCLK(mclk), .RESETN(resetn),
    .CONVERTER_CLOCK_DIVIDER_SELECT(div_sel), .SAMPLE_WIDTH_SELECT(samp_sel),
    .RESOLUTION_SELECT(res_sel), .CHANNEL_MASTER_ENABLE(ch_en),
    .INPUT_CHANNEL_SELECT(ch_sel), .EXTERNAL_REF_ENABLE(ext_ref),
    .INTERNAL_REF_LEVEL(int_ref), .PORTA_ANALOG_ONLY(pa_ao), .PORTB_ANALOG_ONLY(pb_ao),
    .CONVERTER_ENABLE(conv_en), .CONVERSION_START(start),
    .CONVERSION_IRQ_ENABLE(irq_en), .GLOBAL_IRQ_ENABLE(gie),
    .COMPARATOR_OUT(comp), .TRIAL_CODE(trial), .SAMPLE_PULSE(samp_pulse),
    .CONVERTER_CLOCK(conv_clk), .ANALOG_ROUTE(route),
    .PORTA_DIGITAL_OFF(pa_off), .PORTB_DIGITAL_OFF(pb_off),
    .CONVERSION_DONE(done), .CONVERSION_RESULT(result), .CONVERSION_IRQ(irq)
  );

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  // Ideal comparator; settles well before the next rising edge
  always @(negedge mclk) comp <= (vin >= trial);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic stop_test();
    $display("checks %0d, mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic check(input logic ok, input string msg);
    check_count++;
    if (ok !== 1'b1) begin
      fail_count++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask

  function automatic sac_pkg::sac_route_s exp_route(input logic en, input logic [3:0] ch,
                                                    input logic ext, input logic [1:0] lvl);
    sac_pkg::sac_route_s r;
    r = '0;
    if (en) begin
      if (ch <= 4'h4) r.pa_sel[ch] = 1'b1;
      else if (ch <= 4'hB) r.pb_sel[ch - 4'h5] = 1'b1;
      else if (ch == 4'hC) r.quarter_sel = 1'b1;
      else if (ch == 4'hD) r.ground_sel = 1'b1;
    end
    if (ext) r.ref_sel[0] = 1'b1;
    else r.ref_sel[4 - lvl] = 1'b1;
    return r;
  endfunction

  // One conversion; live settings are scrambled once it is taken
  task automatic run(input logic [1:0] d, input logic [1:0] s, input logic [1:0] b,
                     input logic [11:0] v, input logic ie, input logic ge, input bit poke);
    int r, sw, bits, n, ticks, shigh;
    logic [11:0] mask;
    logic low_seen;
    sac_pkg::sac_route_s er;
    r = (d == 2'h0) ? 16 : (d == 2'h1) ? 8 : (d == 2'h2) ? 1 : 2;
    sw = 1 << s;
    bits = (b == 2'h0) ? 8 : (b == 2'h1) ? 10 : 12;
    mask = 12'hFFF << (12 - bits);
    er = exp_route(ch_en, ch_sel, ext_ref, int_ref);
    @(negedge mclk);
    div_sel = d;
    samp_sel = s;
    res_sel = b;
    vin = v;
    irq_en = ie;
    gie = ge;
    start = 1'b1;
    @(posedge mclk);
    // Past the launch edge, so the cleared done flag is seen
    #1;
    n = 0;
    ticks = 0;
    shigh = 0;
    low_seen = 1'b0;
    while (done !== 1'b1 && n < 2000) begin
      @(negedge mclk);
      n++;
      if (conv_clk === 1'b1) ticks++;
      if (samp_pulse === 1'b1) shigh++;
      if (n == 1) begin
        low_seen = (done === 1'b0);
        start = 1'b0;
        div_sel = ~d;
        samp_sel = ~s;
        res_sel = ~b;
        ch_sel = ~ch_sel;
        ext_ref = ~ext_ref;
      end
      if (poke && n == 3) start = 1'b1;
      if (poke && n == 4) start = 1'b0;
      @(posedge mclk);
      #1;
    end
    if (n >= 2000) begin
      check(1'b0, "done never rose");
      stop_test();
    end else begin
      check(low_seen, "done not low while busy");
      check(n == (sw + bits + 2) * r, "conversion length");
      check(ticks == sw + bits + 2, "converter clock count");
      check(shigh == sw * r, "sample pulse width");
      check(result === (v & mask), "conversion result");
      check(irq === (ie & ge), "interrupt at done");
      check(route === er, "route held during conversion");
      @(posedge mclk);
      #1;
      check(irq === 1'b0 && done === 1'b1, "irq pulse or done level");
      check(result === (v & mask), "result held");
    end
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    resetn = 1'b0;
    {div_sel, samp_sel, res_sel, int_ref} = 8'h00;
    {ch_en, ext_ref, conv_en, start, irq_en, gie} = 6'h00;
    ch_sel = 4'h0;
    pa_ao = 5'h00;
    pb_ao = 7'h00;
    vin = 12'h000;
    fail_count = 0;
    check_count = 0;
    repeat (8) @(posedge mclk);
    #1;
    check(done === 1'b0 && result === 12'h000 && irq === 1'b0, "reset values");
    check(trial === 12'h000 && samp_pulse === 1'b0 && conv_clk === 1'b0, "reset sequencer");
    check(route === '0 && pa_off === 5'h00 && pb_off === 7'h00, "reset routing");
    @(negedge mclk);
    resetn = 1'b1;
    // Every channel code with and without master enable, all references
    for (i = 0; i < 32; i++) begin
      @(negedge mclk);
      ch_en = i[4];
      ch_sel = i[3:0];
      ext_ref = i[0];
      int_ref = i[2:1];
      pa_ao = 5'h01 << (i % 5);
      pb_ao = 7'h01 << (i % 7);
      @(posedge mclk);
      #1;
      check(route === exp_route(ch_en, ch_sel, ext_ref, int_ref), "idle route");
      check(pa_off === pa_ao && pb_off === pb_ao, "digital off copy");
    end
    // Start while disabled is ignored
    @(negedge mclk);
    start = 1'b1;
    bad = 1'b0;
    for (k = 0; k < 20; k++) begin
      @(posedge mclk);
      #1;
      if (samp_pulse !== 1'b0 || done !== 1'b0) bad = 1'b1;
    end
    check(!bad, "start taken while disabled");
    @(negedge mclk);
    start = 1'b0;
    conv_en = 1'b1;
    // Firmware lets the bias settle before its first start
    repeat (BIAS_WAIT) @(negedge mclk);
    // Sweep of divider, sample width and resolution codes
    for (i = 0; i < 64; i++) begin
      @(negedge mclk);
      ch_en = 1'b1;
      ch_sel = 4'(i % 14);
      ext_ref = i[1];
      int_ref = i[3:2];
      run(i[1:0], i[3:2], i[5:4], vals[i % 6], i[0] | i[3], i[1] | i[4], i[2]);
    end
    // Abort by dropping the enable in mid conversion
    prev = result;
    @(negedge mclk);
    div_sel = 2'h0;
    samp_sel = 2'h3;
    res_sel = 2'h2;
    irq_en = 1'b1;
    gie = 1'b1;
    start = 1'b1;
    @(negedge mclk);
    start = 1'b0;
    repeat (10) @(negedge mclk);
    conv_en = 1'b0;
    bad = 1'b0;
    for (k = 0; k < 400; k++) begin
      @(posedge mclk);
      #1;
      if (done !== 1'b0 || irq !== 1'b0 || result !== prev) bad = 1'b1;
    end
    check(!bad, "abort did not hold");
    @(negedge mclk);
    conv_en = 1'b1;
    run(2'h2, 2'h0, 2'h0, 12'h3C7, 1'b1, 1'b1, 1'b0);
    stop_test();
  end
endmodule // tb_sac_ctrl
